// File: design/rst_seq_pkg.sv
// Constants and types shared by the reset sequencer files.
// Assumes a single 100 MHz clock; all delays but the crystal start-up count are counted from it.
package rst_seq_pkg;

	// Clock and the timebase derived from it, standing in for the timer oscillator
	localparam int CLK_NS      = 10;
	localparam int TICK_NS     = 1000;
	localparam int TICK_CYC    = TICK_NS / CLK_NS;
	localparam int TICK_W      = 7;

	// Power-up delay, in milliseconds and in timebase ticks
	localparam int POWER_UP_DELAY_TIMER_MS       = 72;
	localparam int POWER_UP_DELAY_TIMER_TICKS_DEF = POWER_UP_DELAY_TIMER_MS * 1000000 / TICK_NS;

	// Short RC-option delay, in microseconds and in ticks
	localparam int RCDLY_US    = 250;
	localparam int RCDLY_TICKS = RCDLY_US * 1000 / TICK_NS;

	// Oscillator start-up length in crystal input periods
	localparam int OST_CYC     = 1024;
	localparam int CNT_W       = 17;

	// Shortest master-clear pulse honoured, rounded up to cycles
	localparam int MASTER_CLEAR_PIN_MIN_NS  = 2000;
	localparam int MASTER_CLEAR_PIN_MIN_CYC = (MASTER_CLEAR_PIN_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int XTAL_MIN_CYC = 1;

	// Register port
	localparam int AW = 4;
	localparam int DW = 8;
	localparam logic [AW-1:0] OFS_CONFIG = 4'h0;
	localparam logic [AW-1:0] OFS_STATUS = 4'h4;
	localparam logic [AW-1:0] OFS_STATE  = 4'h8;

	typedef enum logic [1:0] {
		RESISTOR_CAPACITOR_OSC_MODE,
		LOW_POWER_CRYSTAL_MODE,
		STANDARD_CRYSTAL_MODE,
		HIGH_SPEED_CRYSTAL_MODE
	} osc_mode_t;

	// Configuration: bit0 delay enable (low), bits2:1 mode,
	// bit3 brown-out enable, bit4 internal/external RC option
	typedef struct packed {
		logic      rc_option;
		logic      brownout_detect_enable;
		osc_mode_t osc;
		logic      power_up_delay_enable_n;
	} cfg_t;
	localparam int   CFG_W   = $bits(cfg_t);
	localparam cfg_t CFG_RST = cfg_t'(5'h00);

	// Cause flags, all active low except none; bit0 upward
	typedef struct packed {
		logic parity_error_reset;
		logic brownout_reset;
		logic power_on;
		logic powerdown_flag;
		logic watchdog_expired_flag;
	} cause_t;
	localparam int     CAUSE_W   = $bits(cause_t);
	localparam cause_t CAUSE_RST = cause_t'(5'h1B);

	typedef enum logic [2:0] {
		K_NONE, K_POR, K_MASTER_CLEAR_PIN_RUN, K_MASTER_CLEAR_PIN_SLEEP,
		K_WDT_RUN, K_WDT_WAKE, K_BOR, K_PER
	} reset_kind_t;

	typedef enum logic [2:0] {
		S_RUN, S_SLEEP, S_BROWN, S_POWER_UP_DELAY_TIMER, S_OST, S_RCDLY, S_PULSE
	} seq_state_t;

endpackage

// File: design/pin_filter.sv
// Two-flop synchroniser with a stability filter for a pin.
// Assumes the pin is asynchronous to clk.
module pin_filter
	import rst_seq_pkg::*;
#(
	parameter int   STABLE = 1,
	parameter logic INIT   = 1'b0
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Pin and filtered level
	input  wire logic pin,
	output logic      level
);

	logic            sync1;
	logic            sync2;
	logic [CNT_W-1:0] cnt;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1 <= INIT;
			sync2 <= INIT;
		end else begin
			sync1 <= pin;
			sync2 <= sync1;
		end
	end

	// Level follows only after STABLE equal samples
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt   <= '0;
			level <= INIT;
		end else if (sync2 == level) begin
			cnt <= '0;
		end else if (cnt == CNT_W'(STABLE - 1)) begin
			cnt   <= '0;
			level <= sync2;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	property p_short_ignored;
		@(posedge clk) disable iff (!nrst)
		$changed(level) |-> $past(cnt) == CNT_W'(STABLE - 1);
	endproperty
	a_short_ignored: assert property (p_short_ignored)
		else $error("pin level changed before filter time");

endmodule

// File: design/reset_timeout_sequencer.sv
// Reset sequencer: reset causes, power-up delay, start-up counter.
// Assumes detector flags are synchronous to clk; pins are not.
module reset_timeout_sequencer
	import rst_seq_pkg::*;
#(
	parameter int POWER_UP_DELAY_TIMER_TICKS = POWER_UP_DELAY_TIMER_TICKS_DEF
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          nrst,
	// Pins
	input  wire logic          master_clear_pin,
	input  wire logic          crystal_input_pin,
	// Analog detector flags
	input  wire logic          por_detect,
	input  wire logic          brownout_low,
	input  wire logic          osc_amp_ok,
	// Core events
	input  wire logic          watchdog_timeout,
	input  wire logic          sleep_enter,
	input  wire logic          wake_interrupt,
	input  wire logic          parity_error,
	// Register port
	input  wire logic [AW-1:0] reg_addr,
	input  wire logic [DW-1:0] reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [DW-1:0] reg_rdata,
	// Core control
	output logic               core_reset,
	output logic               reg_init,
	output logic               core_stall,
	output logic               wake_resume,
	output logic               sleeping,
	output logic      [1:0]    phase,
	output reset_kind_t        reset_kind
);

	cfg_t             cfg;
	cause_t           cause;
	cause_t           next_cause;
	seq_state_t       state;
	seq_state_t       next_state;
	reset_kind_t      next_kind;
	logic [CNT_W-1:0] cnt;
	logic [TICK_W-1:0] div;
	logic             tick;
	logic             master_clear_pin_ok;
	logic             master_clear_pin_low;
	logic             master_clear_pin_prev;
	logic             master_clear_pin_fall;
	logic             xtal;
	logic             xtal_prev;
	logic             xtal_edge;
	logic             bor_active;
	logic             waking;
	logic             next_waking;
	logic             hold;

	function automatic logic is_crystal(input cfg_t c);
		return c.osc != RESISTOR_CAPACITOR_OSC_MODE;
	endfunction

	// Time-out taken in place of the power-up delay, or on wake from sleep
	function automatic seq_state_t after_delay(input cfg_t c);
		if (is_crystal(c))
			return S_OST;
		else if (c.rc_option)
			return S_RCDLY;
		else
			return S_RUN;
	endfunction

	pin_filter #(
		.STABLE (MASTER_CLEAR_PIN_MIN_CYC),
		.INIT   (1'b1)
	) u_master_clear_pin (
		.clk   (clk),
		.nrst  (nrst),
		.pin   (master_clear_pin),
		.level (master_clear_pin_ok)
	);

	pin_filter #(
		.STABLE (XTAL_MIN_CYC),
		.INIT   (1'b0)
	) u_xtal (
		.clk   (clk),
		.nrst  (nrst),
		.pin   (crystal_input_pin),
		.level (xtal)
	);

	assign master_clear_pin_low   = !master_clear_pin_ok;
	assign master_clear_pin_fall  = master_clear_pin_prev && !master_clear_pin_ok;
	assign xtal_edge  = xtal && !xtal_prev;
	assign bor_active = cfg.brownout_detect_enable && brownout_low;
	assign tick       = div == TICK_W'(TICK_CYC - 1);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			master_clear_pin_prev <= 1'b1;
			xtal_prev <= 1'b0;
		end else begin
			master_clear_pin_prev <= master_clear_pin_ok;
			xtal_prev <= xtal;
		end
	end

	// Free-running timebase standing in for the delay oscillator
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			div <= '0;
		else if (tick)
			div <= '0;
		else
			div <= div + 1'b1;
	end

	always_comb begin
		next_state  = state;
		next_waking = waking;
		if (por_detect) begin
			next_waking = 1'b0;
			if (!cfg.power_up_delay_enable_n)
				next_state = S_POWER_UP_DELAY_TIMER;
			else
				next_state = after_delay(cfg);
		end else if (bor_active) begin
			next_waking = 1'b0;
			next_state  = S_BROWN;
		end else begin
			unique case (state)
				S_RUN: begin
					if (!master_clear_pin_low && (watchdog_timeout || parity_error))
						next_state = S_PULSE;
					else if (!master_clear_pin_low && sleep_enter)
						next_state = S_SLEEP;
				end
				S_SLEEP: begin
					if (master_clear_pin_low) begin
						next_state = after_delay(cfg);
					end else if (watchdog_timeout || wake_interrupt) begin
						next_waking = 1'b1;
						next_state  = after_delay(cfg);
					end
				end
				S_BROWN:
					next_state = S_POWER_UP_DELAY_TIMER;
				S_POWER_UP_DELAY_TIMER: begin
					if (tick && cnt == CNT_W'(POWER_UP_DELAY_TIMER_TICKS - 1))
						next_state = is_crystal(cfg) ? S_OST : S_RUN;
				end
				S_OST: begin
					if (xtal_edge && osc_amp_ok
					    && cnt == CNT_W'(OST_CYC - 1))
						next_state = S_RUN;
				end
				S_RCDLY: begin
					if (tick && cnt == CNT_W'(RCDLY_TICKS - 1))
						next_state = S_RUN;
				end
				S_PULSE:
					next_state = S_RUN;
			endcase
		end
		if (next_state == S_RUN)
			next_waking = 1'b0;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state  <= S_POWER_UP_DELAY_TIMER;
			waking <= 1'b0;
		end else begin
			state  <= next_state;
			waking <= next_waking;
		end
	end

	// One counter serves every time-out; cleared on each new state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			cnt <= '0;
		else if (next_state != state || state == S_BROWN || por_detect)
			cnt <= '0;
		else if (state == S_OST && xtal_edge && osc_amp_ok)
			cnt <= cnt + 1'b1;
		else if ((state == S_POWER_UP_DELAY_TIMER || state == S_RCDLY) && tick)
			cnt <= cnt + 1'b1;
	end

	// Reset kind and cause flags; hardware events override writes
	always_comb begin
		next_cause = cause;
		next_kind  = reset_kind;
		if (reg_wr && reg_addr == OFS_STATUS) begin
			next_cause.parity_error_reset = reg_wdata[4];
			next_cause.brownout_reset     = reg_wdata[3];
			next_cause.power_on           = reg_wdata[2];
		end
		if (por_detect) begin
			next_kind                        = K_POR;
			next_cause.power_on              = 1'b0;
			next_cause.watchdog_expired_flag = 1'b1;
			next_cause.powerdown_flag        = 1'b1;
		end else if (bor_active) begin
			if (state != S_BROWN) begin
				next_kind                        = K_BOR;
				next_cause.brownout_reset        = 1'b0;
				next_cause.watchdog_expired_flag = 1'b1;
				next_cause.powerdown_flag        = 1'b1;
			end
		end else if (state == S_RUN) begin
			if (master_clear_pin_fall) begin
				next_kind = K_MASTER_CLEAR_PIN_RUN;
			end else if (!master_clear_pin_low && watchdog_timeout) begin
				next_kind                        = K_WDT_RUN;
				next_cause.watchdog_expired_flag = 1'b0;
				next_cause.powerdown_flag        = 1'b1;
			end else if (!master_clear_pin_low && parity_error) begin
				next_kind                     = K_PER;
				next_cause.parity_error_reset = 1'b0;
			end else if (!master_clear_pin_low && sleep_enter) begin
				next_cause.watchdog_expired_flag = 1'b1;
				next_cause.powerdown_flag        = 1'b0;
			end
		end else if (state == S_SLEEP) begin
			if (master_clear_pin_low) begin
				next_kind                        = K_MASTER_CLEAR_PIN_SLEEP;
				next_cause.watchdog_expired_flag = 1'b1;
				next_cause.powerdown_flag        = 1'b0;
			end else if (watchdog_timeout) begin
				next_kind                        = K_WDT_WAKE;
				next_cause.watchdog_expired_flag = 1'b0;
				next_cause.powerdown_flag        = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cause      <= CAUSE_RST;
			reset_kind <= K_POR;
		end else begin
			cause      <= next_cause;
			reset_kind <= next_kind;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			cfg <= CFG_RST;
		else if (reg_wr && reg_addr == OFS_CONFIG)
			cfg <= cfg_t'(reg_wdata[CFG_W-1:0]);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			reg_rdata <= '0;
		else if (!reg_rd)
			reg_rdata <= '0;
		else
			unique case (reg_addr)
				OFS_CONFIG: reg_rdata <= DW'(cfg);
				OFS_STATUS: reg_rdata <= DW'(cause);
				OFS_STATE:  reg_rdata <= {1'h0, waking, reset_kind, state};
				default:    reg_rdata <= '0;
			endcase
	end

	// Core hold: time-outs, filtered master-clear, brown-out
	assign hold = (next_state != S_RUN && next_state != S_SLEEP)
	              || master_clear_pin_low || bor_active || por_detect;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			core_reset  <= 1'b1;
			reg_init    <= 1'b1;
			core_stall  <= 1'b1;
			sleeping    <= 1'b0;
			wake_resume <= 1'b0;
		end else begin
			core_reset  <= hold && !next_waking;
			reg_init    <= hold && !next_waking;
			core_stall  <= hold || next_state == S_SLEEP;
			sleeping    <= next_state == S_SLEEP;
			wake_resume <= next_state == S_RUN && !hold
			               && (waking || state == S_SLEEP);
		end
	end

	// Four-phase instruction clock, parked at the first phase
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			phase <= 2'h0;
		else if (hold || next_state == S_SLEEP || core_stall)
			phase <= 2'h0;
		else
			phase <= phase + 2'h1;
	end

	sequence s_power_up_delay_timer_done;
		state == S_POWER_UP_DELAY_TIMER ##1 state == S_OST;
	endsequence

	sequence s_quiet;
		!por_detect && !bor_active;
	endsequence

	property p_order;
		@(posedge clk) disable iff (!nrst)
		s_power_up_delay_timer_done |-> is_crystal(cfg);
	endproperty
	a_order: assert property (p_order)
		else $error("start-up timer entered in RC mode");

	property p_power_up_delay_timer_on_por;
		@(posedge clk) disable iff (!nrst)
		por_detect && !cfg.power_up_delay_enable_n
		|=> state == S_POWER_UP_DELAY_TIMER && cnt == '0;
	endproperty
	a_power_up_delay_timer_on_por: assert property (p_power_up_delay_timer_on_por)
		else $error("power-up delay not started on power-on");

	property p_no_timeout;
		@(posedge clk) disable iff (!nrst)
		por_detect && cfg.power_up_delay_enable_n && !is_crystal(cfg)
		&& !cfg.rc_option |=> state == S_RUN;
	endproperty
	a_no_timeout: assert property (p_no_timeout)
		else $error("time-out applied in RC mode with delay off");

	property p_hold_in_power_up_delay_timer;
		@(posedge clk) disable iff (!nrst)
		state == S_POWER_UP_DELAY_TIMER && $past(state) == S_POWER_UP_DELAY_TIMER |-> core_reset;
	endproperty
	a_hold_in_power_up_delay_timer: assert property (p_hold_in_power_up_delay_timer)
		else $error("core released during power-up delay");

	property p_phase_parked;
		@(posedge clk) disable iff (!nrst)
		core_reset |-> phase == 2'h0 && core_stall;
	endproperty
	a_phase_parked: assert property (p_phase_parked)
		else $error("phase moving while in reset");

	property p_ost_length;
		@(posedge clk) disable iff (!nrst)
		(state == S_OST && cnt != CNT_W'(OST_CYC - 1)) and s_quiet
		|=> state == S_OST;
	endproperty
	a_ost_length: assert property (p_ost_length)
		else $error("start-up timer ended early");

	property p_ost_amplitude;
		@(posedge clk) disable iff (!nrst)
		(state == S_OST && !osc_amp_ok) and s_quiet
		|=> cnt == $past(cnt);
	endproperty
	a_ost_amplitude: assert property (p_ost_amplitude)
		else $error("start-up count moved without amplitude");

	property p_power_up_delay_timer_ignores_master_clear_pin;
		@(posedge clk) disable iff (!nrst)
		(state == S_POWER_UP_DELAY_TIMER && master_clear_pin_low && tick
		&& cnt != CNT_W'(POWER_UP_DELAY_TIMER_TICKS - 1)) and s_quiet
		|=> cnt == $past(cnt) + 1'b1;
	endproperty
	a_power_up_delay_timer_ignores_master_clear_pin: assert property (p_power_up_delay_timer_ignores_master_clear_pin)
		else $error("power-up delay stalled by master-clear");

	property p_bor_restart;
		@(posedge clk) disable iff (!nrst)
		bor_active && !por_detect ##1 !bor_active && !por_detect
		|=> state == S_POWER_UP_DELAY_TIMER && cnt == '0;
	endproperty
	a_bor_restart: assert property (p_bor_restart)
		else $error("brown-out did not restart power-up delay");

	property p_wdt_flags;
		@(posedge clk) disable iff (!nrst)
		(state == S_RUN && watchdog_timeout && !master_clear_pin_low && !master_clear_pin_fall)
		and s_quiet |=> !cause.watchdog_expired_flag
		&& cause.powerdown_flag && reset_kind == K_WDT_RUN;
	endproperty
	a_wdt_flags: assert property (p_wdt_flags)
		else $error("watchdog reset flags wrong");

	property p_wake_no_reset;
		@(posedge clk) disable iff (!nrst)
		(state == S_SLEEP && wake_interrupt && !master_clear_pin_low) and s_quiet
		|=> !core_reset && !reg_init;
	endproperty
	a_wake_no_reset: assert property (p_wake_no_reset)
		else $error("wake from sleep reset the core");

endmodule

// File: verification/board_model.sv
// Board model: supply detector, master-clear pin and crystal.
// Assumes bench requests change right after a rising clk edge.
module board_model (
	// Clock
	input  wire logic clk,
	// Bench requests
	input  wire logic supply_rise,
	input  wire logic master_clear_pin_hold,
	input  wire logic brown,
	input  wire logic xtal_run,
	// Board side
	output logic      master_clear_pin,
	output logic      por_detect,
	output logic      brownout_low,
	output logic      osc_amp_ok,
	output logic      crystal_input_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div;
	// Pull-up lifts the pin whenever nobody holds it low
	assign master_clear_pin = !master_clear_pin_hold;
	initial begin
		div = 2'h0;
		crystal_input_pin = 1'b0;
		{por_detect, brownout_low, osc_amp_ok} = 3'h0;
	end
	// Detectors reach the sequencer as clocked flags
	always @(posedge clk) begin
		por_detect <= supply_rise;
		brownout_low <= brown;
		osc_amp_ok <= xtal_run;
		div <= div + 2'h1;
		// Crystal of eight clk periods; stands still while stopped
		if (xtal_run && div == 2'h3)
			crystal_input_pin <= !crystal_input_pin;
	end
endmodule

// File: verification/reset_timeout_sequencer_test.sv
// Self-checking bench for the reset sequencer.
// Assumes a 20-tick power-up delay and the board model as far side.
module reset_timeout_sequencer_test import rst_seq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic          clk, nrst, supply_rise, master_clear_pin_hold, brown, xtal_run;
	logic          master_clear_pin, crystal_input_pin, por_detect;
	logic          brownout_low, osc_amp_ok, watchdog_timeout;
	logic          sleep_enter, wake_interrupt, parity_error;
	logic          reg_wr, reg_rd, core_reset, reg_init, core_stall;
	logic          wake_resume, sleeping;
	logic [AW-1:0] reg_addr;
	logic [DW-1:0] reg_wdata, reg_rdata, d;
	logic [1:0]    phase;
	reset_kind_t   reset_kind;
	int            mismatches, checks_done, n;

	board_model board (.clk(clk), .supply_rise(supply_rise),
		.master_clear_pin_hold(master_clear_pin_hold), .brown(brown), .xtal_run(xtal_run),
		.master_clear_pin(master_clear_pin), .por_detect(por_detect),
		.brownout_low(brownout_low), .osc_amp_ok(osc_amp_ok),
		.crystal_input_pin(crystal_input_pin));

	reset_timeout_sequencer #(.POWER_UP_DELAY_TIMER_TICKS(20)) DUT (.clk(clk), .nrst(nrst),
		.master_clear_pin(master_clear_pin),
		.crystal_input_pin(crystal_input_pin), .por_detect(por_detect),
		.brownout_low(brownout_low), .osc_amp_ok(osc_amp_ok),
		.watchdog_timeout(watchdog_timeout), .sleep_enter(sleep_enter),
		.wake_interrupt(wake_interrupt), .parity_error(parity_error),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_reset(core_reset),
		.reg_init(reg_init), .core_stall(core_stall),
		.wake_resume(wake_resume), .sleeping(sleeping), .phase(phase),
		.reset_kind(reset_kind));

	always #5 clk = !clk;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input int got, input int lo, input int hi);
		checks_done++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [AW-1:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// One-cycle core event: 0 watchdog, 1 wake, 2 sleep, 3 parity
	task automatic ev(input int k);
		@(posedge clk);
		{parity_error, sleep_enter, wake_interrupt, watchdog_timeout}
			<= 4'(1 << k);
		@(posedge clk);
		{parity_error, sleep_enter, wake_interrupt, watchdog_timeout} <= 4'h0;
		#1;
	endtask

	// Cycles until core release, or until the wake pulse
	task automatic wait_for(input bit on_wake, input int lo, input int hi);
		n = 0;
		while ((on_wake ? wake_resume !== 1'b1 : core_reset !== 1'b0)
			&& n < 30000) begin
			@(posedge clk);
			#1 n++;
		end
		chk_rng(n, lo, hi);
	endtask

	task automatic t_power_on;
		chk(core_reset, 8'h01);
		chk(reg_init, 8'h01);
		chk(phase, 8'h00);
		chk(reset_kind, K_POR);
		rd(OFS_STATUS);
		chk(d, 8'h1B);
		rd(OFS_CONFIG);
		chk(d, 8'h00);
		rd(4'hC);
		chk(d, 8'h00);
		wr(OFS_STATE, 8'hFF);
		wait_for(0, 1850, 2150);
		chk(phase, 8'h00);
		rd(OFS_STATE);
		chk(d[2:0], 8'h00);
	endtask

	task automatic t_run_resets;
		wr(OFS_STATUS, 8'h1F);
		ev(0);
		chk(core_reset, 8'h01);
		chk(reset_kind, K_WDT_RUN);
		@(posedge clk);
		#1 chk(core_reset, 8'h00);
		chk(phase, 8'h00);
		rd(OFS_STATUS);
		chk(d, 8'h1E);
		ev(3);
		chk(reg_init, 8'h01);
		chk(reset_kind, K_PER);
		rd(OFS_STATUS);
		chk(d, 8'h0E);
	endtask

	task automatic t_sleep_wdt;
		ev(2);
		chk(sleeping, 8'h01);
		rd(OFS_STATUS);
		chk(d, 8'h0D);
		ev(0);
		chk(reset_kind, K_WDT_WAKE);
		chk(core_reset, 8'h00);
		wait_for(1, 0, 10);
		rd(OFS_STATUS);
		chk(d, 8'h0C);
	endtask

	task automatic t_xtal_wake;
		wr(OFS_CONFIG, 8'h04);
		ev(2);
		ev(1);
		repeat (2000) @(posedge clk);
		#1 chk(core_stall, 8'h01);
		chk(core_reset, 8'h00);
		@(posedge clk);
		xtal_run <= 1'b1;
		wait_for(1, 8150, 8300);
		rd(OFS_STATUS);
		chk(d, 8'h0D);
	endtask

	task automatic t_master_clear_pin;
		@(posedge clk);
		master_clear_pin_hold <= 1'b1;
		repeat (100) @(posedge clk);
		master_clear_pin_hold <= 1'b0;
		repeat (20) @(posedge clk);
		#1 chk(core_reset, 8'h00);
		@(posedge clk);
		master_clear_pin_hold <= 1'b1;
		repeat (400) @(posedge clk);
		#1 chk(reg_init, 8'h01);
		chk(reset_kind, K_MASTER_CLEAR_PIN_RUN);
		rd(OFS_STATUS);
		chk(d, 8'h0D);
		@(posedge clk);
		master_clear_pin_hold <= 1'b0;
		wait_for(0, 195, 230);
		ev(2);
		@(posedge clk);
		master_clear_pin_hold <= 1'b1;
		repeat (300) @(posedge clk);
		#1 chk(core_reset, 8'h01);
		chk(reset_kind, K_MASTER_CLEAR_PIN_SLEEP);
		rd(OFS_STATUS);
		chk(d, 8'h0D);
		@(posedge clk);
		master_clear_pin_hold <= 1'b0;
		wait_for(0, 8000, 8200);
	endtask

	task automatic t_brownout;
		wr(OFS_CONFIG, 8'h08);
		wr(OFS_STATUS, 8'h1F);
		brown <= 1'b1;
		repeat (50) @(posedge clk);
		#1 chk(core_reset, 8'h01);
		chk(reset_kind, K_BOR);
		rd(OFS_STATUS);
		chk(d, 8'h17);
		@(posedge clk);
		brown <= 1'b0;
		repeat (1000) @(posedge clk);
		brown <= 1'b1;
		repeat (50) @(posedge clk);
		brown <= 1'b0;
		wait_for(0, 1850, 2150);
	endtask

	task automatic t_supply_rise;
		wr(OFS_CONFIG, 8'h04);
		master_clear_pin_hold <= 1'b1;
		supply_rise <= 1'b1;
		@(posedge clk);
		supply_rise <= 1'b0;
		repeat (10500) @(posedge clk);
		#1 chk(core_reset, 8'h01);
		chk(reset_kind, K_POR);
		@(posedge clk);
		master_clear_pin_hold <= 1'b0;
		wait_for(0, 195, 230);
		wr(OFS_CONFIG, 8'h01);
		supply_rise <= 1'b1;
		@(posedge clk);
		supply_rise <= 1'b0;
		repeat (10) @(posedge clk);
		#1 chk(core_reset, 8'h00);
		rd(OFS_STATUS);
		chk(d[2:0], 8'h03);
		wr(OFS_CONFIG, 8'h11);
		supply_rise <= 1'b1;
		@(posedge clk);
		supply_rise <= 1'b0;
		@(posedge clk);
		#1 chk(core_reset, 8'h01);
		wait_for(0, 24850, 25050);
	endtask

	task automatic results;
		if (mismatches == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		{nrst, supply_rise, master_clear_pin_hold, brown, xtal_run} = 5'h00;
		{watchdog_timeout, sleep_enter, wake_interrupt, parity_error} = 4'h0;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		#1 t_power_on();
		t_run_resets();
		t_sleep_wdt();
		t_xtal_wake();
		t_master_clear_pin();
		t_brownout();
		t_supply_rise();
		results();
	end

	// Whole run needs about 61000 cycles
	initial begin
		#800us;
		mismatches++;
		results();
	end
endmodule
